// ===== core/timer_pkg.sv
// constants for the sixteen-bit timer/counter with external count clock
package timer_pkg;

  // register byte offsets on the ahb-lite bus
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] count_low_offset = 8'h04;
  localparam logic [7:0] count_high_offset = 8'h08;
  localparam logic [7:0] flag_offset = 8'h0c;
  localparam logic [7:0] compare_low_offset = 8'h10;
  localparam logic [7:0] compare_high_offset = 8'h14;
  localparam logic [7:0] compare_mode_offset = 8'h18;

  // counter_control_reg field positions
  localparam int on_bit = 0;
  localparam int clock_source_select_bit = 1;
  localparam int sync_disable_bit = 2;
  localparam int lp_osc_enable_bit = 3;
  localparam int prescale_lsb = 4;
  localparam int prescale_msb = 5;
  localparam int ctrl_width = 6;

  // peripheral_flag_reg field position
  localparam int overflow_flag_bit = 0;

  // reset values and the top count value
  localparam logic [ctrl_width-1:0] ctrl_reset = 6'h00;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] count_top = 16'hffff;
  localparam logic [15:0] compare_reset = 16'h0000;
  localparam logic [3:0] compare_mode_reset = 4'h0;

  // compare_mode_field code for the special event trigger
  localparam logic [3:0] special_event_mode = 4'hb;

  // prescale_field codes
  localparam logic [1:0] prescale_div1 = 2'h0;
  localparam logic [1:0] prescale_div2 = 2'h1;
  localparam logic [1:0] prescale_div4 = 2'h2;
  localparam logic [1:0] prescale_div8 = 2'h3;

  // internal phase counter: four core clocks make one instruction cycle
  localparam logic [1:0] phase_one_code = 2'h0;
  localparam logic [1:0] phase_two_code = 2'h1;
  localparam logic [1:0] phase_three_code = 2'h2;
  localparam logic [1:0] phase_four_code = 2'h3;

  // ahb-lite encodings
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;

  typedef enum logic [3:0] {
    bus_idle = 4'b0001,
    bus_write = 4'b0010,
    bus_read_wait = 4'b0100,
    bus_read_done = 4'b1000
  } bus_state_t;

endpackage : timer_pkg

// ===== core/count_prescaler.sv
// ripple-style prescaler dividing the selected count source by 1, 2, 4 or 8
module count_prescaler (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic raw_level,
  input wire logic clear,
  input wire logic [1:0] prescale_field,
  output logic divided_level
);
  import timer_pkg::*;

  logic raw_prev;
  logic [2:0] stage;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      raw_prev <= 1'b0;
    end else begin
      raw_prev <= raw_level;
    end
  end

  // stage 0 toggles on each rising source edge and each higher stage on a falling edge of the one below, so every output is symmetrical
  always_ff @(posedge core_clk) begin
    if (srst || clear) begin
      stage <= 3'h0;
    end else if (raw_level && !raw_prev) begin
      stage <= stage + 3'h1;
    end
  end

  // 1:1 passes the source straight through
  always_comb begin
    unique case (prescale_field)
      prescale_div1: divided_level = raw_level;
      prescale_div2: divided_level = stage[0];
      prescale_div4: divided_level = stage[1];
      prescale_div8: divided_level = stage[2];
    endcase
  end

endmodule // count_prescaler

// ===== core/phase_sync.sv
// samples the prescaler output on phase two and phase four and makes a delayed count step
module phase_sync (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic active,
  input wire logic phase_two,
  input wire logic phase_four,
  input wire logic divided_level,
  output logic count_step
);
  import timer_pkg::*;

  logic sampled;
  logic sampled_prev;
  logic rise_seen;

  // sampled only at the two phase points; a pulse must last two phases to be seen
  // while shut off both samples follow the level, so waking up never makes a false edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sampled <= 1'b0;
      sampled_prev <= 1'b0;
    end else if (!active) begin
      sampled <= divided_level;
      sampled_prev <= divided_level;
    end else if (phase_two || phase_four) begin
      sampled <= divided_level;
      sampled_prev <= sampled;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || !active) begin
      rise_seen <= 1'b0;
    end else begin
      rise_seen <= (phase_two || phase_four) && sampled && !sampled_prev;
    end
  end

  // one more stage: the count moves after synchronisation, never on the raw edge
  always_ff @(posedge core_clk) begin
    if (srst || !active) begin
      count_step <= 1'b0;
    end else begin
      count_step <= rise_seen;
    end
  end

endmodule // phase_sync

// ===== core/ext_clock_timer.sv
// sixteen-bit timer/counter with external count clock, ahb-lite register slave

////////////////////////////////////////////////////////////////////////////////
// How it works
// - with 1:1 prescale, sync samples prescaler output on phase two and four
// - synchronized counter steps only after a delay following synchronisation
// - other prescales divide the input by a ripple counter, output symmetrical
// - sync_disable_bit set passes the count input without phase synchronisation
// - asynchronous mode keeps counting in sleep; overflow can wake the core
// - asynchronous mode cannot be the capture or compare time base
// - byte reads of a running count always return a valid value
// - lp_osc_enable switches on the low-power oscillator, running in sleep
// - compare special-event mode 1011 trigger resets the count pair
// - a trigger reset never sets the overflow flag
// - trigger reset works in timer or synchronized mode only
// - a count write in the trigger cycle wins over the reset
// - compare pair acts as period: count restarts on match
// - count runs 0000h to FFFFh, wraps, and latches the overflow flag
// - synchronized mode does not count in sleep; prescaler keeps counting
// - prescale codes 11, 10, 01, 00 give 1:8, 1:4, 1:2, 1:1
// - clock_source_select set takes the pin rising edges, clear takes fosc/4
module ext_clock_timer #(
  parameter int addr_width = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [addr_width-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic sleep,
  input wire logic ext_count_input,
  input wire logic lp_osc_in,
  output logic lp_osc_out,
  output logic overflow_flag,
  output logic wake_req,
  output logic timebase_valid,
  output logic compare_trigger
);
  import timer_pkg::*;

  // the map reaches offset 18h, so five address bits are the least the decoder can serve
  if (addr_width < 5) begin : g_width_check
    $error("addr_width too small for the register map");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers and internal signals

  logic [ctrl_width-1:0] counter_control_reg;
  logic [15:0] count_pair;
  logic [15:0] compare_pair;
  logic [3:0] compare_mode_field;
  logic [1:0] phase;
  logic instr_level;
  logic count_source;
  logic divided_level;
  logic divided_prev;
  logic divided_rise;
  logic sync_step;
  logic count_step;
  logic counter_on;
  logic external_mode;
  logic async_mode;
  logic trigger_pending;
  logic count_write;
  logic bus_accept;
  bus_state_t bus_state;
  logic [7:0] data_addr;
  logic [31:0] read_value;

  assign counter_on = counter_control_reg[on_bit];
  assign external_mode = counter_control_reg[clock_source_select_bit];
  // the sync bit is ignored while the internal clock is selected
  assign async_mode = external_mode && counter_control_reg[sync_disable_bit];

  function automatic logic is_offset(input logic [7:0] addr, input logic [7:0] offset);
    is_offset = (addr == offset);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // phase clocks: four core clocks to one instruction cycle

  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase <= phase_one_code;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // high in phases three and four, so its rising edge marks fosc/4
  assign instr_level = phase[1];

  ////////////////////////////////////////////////////////////////////////////////
  // low-power oscillator and count source

  // the amplifier output is the inverted input while enabled, parked low otherwise;
  // it is not gated by sleep, so the crystal keeps running
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lp_osc_out <= 1'b0;
    end else begin
      lp_osc_out <= counter_control_reg[lp_osc_enable_bit] && !lp_osc_in;
    end
  end

  // pin edges when the source bit is set, instruction clock otherwise
  always_comb begin
    if (!external_mode) begin
      count_source = instr_level;
    end else if (counter_control_reg[lp_osc_enable_bit]) begin
      count_source = lp_osc_in;
    end else begin
      count_source = ext_count_input;
    end
  end

  // the prescaler is never gated by sleep, as in the real ripple chain
  count_prescaler u_prescaler (
    .core_clk(core_clk),
    .srst(srst),
    .raw_level(count_source),
    .clear(count_write),
    .prescale_field(counter_control_reg[prescale_msb:prescale_lsb]),
    .divided_level(divided_level)
  );

  // the synchroniser is shut off in sleep and when synchronisation is disabled
  phase_sync u_phase_sync (
    .core_clk(core_clk),
    .srst(srst),
    .active(external_mode && !async_mode && !sleep),
    .phase_two(phase == phase_two_code),
    .phase_four(phase == phase_four_code),
    .divided_level(divided_level),
    .count_step(sync_step)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      divided_prev <= 1'b0;
    end else begin
      divided_prev <= divided_level;
    end
  end

  assign divided_rise = divided_level && !divided_prev;

  // step selection per mode
  always_comb begin
    if (!counter_on) begin
      count_step = 1'b0;
    end else if (async_mode) begin
      count_step = divided_rise;
    end else if (external_mode) begin
      count_step = sync_step;
    end else begin
      count_step = divided_rise && !sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare special event trigger

  // match on the period value while in special-event mode; not offered in
  // asynchronous mode, where the reset could be lost anyway
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trigger_pending <= 1'b0;
    end else begin
      // a match lasts until the clear lands, so block it while a trigger is in flight
      trigger_pending <= (compare_mode_field == special_event_mode) && !async_mode
        && (count_pair == compare_pair) && !trigger_pending && !compare_trigger;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      compare_trigger <= 1'b0;
    end else begin
      compare_trigger <= trigger_pending;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      timebase_valid <= 1'b0;
    end else begin
      timebase_valid <= !async_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave

  assign bus_accept = hsel && hready && htrans[1];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_state <= bus_idle;
    end else begin
      unique case (bus_state)
        bus_idle, bus_write, bus_read_done: begin
          if (bus_accept && hwrite) begin
            bus_state <= bus_write;
          end else if (bus_accept) begin
            bus_state <= bus_read_wait;
          end else begin
            bus_state <= bus_idle;
          end
        end
        bus_read_wait: begin
          bus_state <= bus_read_done;
        end
        default: begin
          bus_state <= bus_idle;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_addr <= 8'h00;
    end else if (bus_accept) begin
      data_addr <= 8'({haddr[addr_width-1:2], 2'h0});
    end
  end

  // one wait state on reads so hrdata comes from a flop and sees any preceding write
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(bus_accept && !hwrite && bus_state != bus_read_wait);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // count bytes are read straight from the single-domain count, always coherent
  always_comb begin
    read_value = 32'h0000_0000;
    if (is_offset(data_addr, ctrl_offset)) begin
      read_value[ctrl_width-1:0] = counter_control_reg;
    end else if (is_offset(data_addr, count_low_offset)) begin
      read_value[7:0] = count_pair[7:0];
    end else if (is_offset(data_addr, count_high_offset)) begin
      read_value[7:0] = count_pair[15:8];
    end else if (is_offset(data_addr, flag_offset)) begin
      read_value[overflow_flag_bit] = overflow_flag;
    end else if (is_offset(data_addr, compare_low_offset)) begin
      read_value[7:0] = compare_pair[7:0];
    end else if (is_offset(data_addr, compare_high_offset)) begin
      read_value[7:0] = compare_pair[15:8];
    end else if (is_offset(data_addr, compare_mode_offset)) begin
      read_value[3:0] = compare_mode_field;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_state == bus_read_wait) begin
      hrdata <= read_value;
    end
  end

  assign count_write = (bus_state == bus_write)
    && (is_offset(data_addr, count_low_offset) || is_offset(data_addr, count_high_offset));

  ////////////////////////////////////////////////////////////////////////////////
  // control and compare registers

  always_ff @(posedge core_clk) begin
    if (srst) begin
      counter_control_reg <= ctrl_reset;
    end else if (bus_state == bus_write && is_offset(data_addr, ctrl_offset)) begin
      counter_control_reg <= hwdata[ctrl_width-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      compare_pair <= compare_reset;
    end else if (bus_state == bus_write && is_offset(data_addr, compare_low_offset)) begin
      compare_pair[7:0] <= hwdata[7:0];
    end else if (bus_state == bus_write && is_offset(data_addr, compare_high_offset)) begin
      compare_pair[15:8] <= hwdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      compare_mode_field <= compare_mode_reset;
    end else if (bus_state == bus_write && is_offset(data_addr, compare_mode_offset)) begin
      compare_mode_field <= hwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // count pair

  // a byte write replaces that byte and wins over both a step and a trigger;
  // a write during a running count loses that one step, which is why software
  // stops the counter first
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_pair <= count_reset;
    end else if (count_write && is_offset(data_addr, count_low_offset)) begin
      count_pair[7:0] <= hwdata[7:0];
    end else if (count_write) begin
      count_pair[15:8] <= hwdata[7:0];
    end else if (compare_trigger) begin
      count_pair <= count_reset;
    end else if (count_step) begin
      count_pair <= count_pair + 16'h0001;
    end
  end

  // only a real wrap sets the flag, never a trigger reset; set beats clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      overflow_flag <= 1'b0;
    end else if (count_step && count_pair == count_top && !count_write && !compare_trigger) begin
      overflow_flag <= 1'b1;
    end else if (bus_state == bus_write && is_offset(data_addr, flag_offset)
        && hwdata[overflow_flag_bit]) begin
      overflow_flag <= 1'b0;
    end
  end

  // wake only comes from a wrap while asleep, which only the async path can do
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= sleep && count_step && count_pair == count_top && !count_write && !compare_trigger;
    end
  end

endmodule // ext_clock_timer

// ===== testbench/ext_clock_timer_props.sv
// assertion checker on the timer's bus, flag, wake and trigger ports
module ext_clock_timer_props
  import timer_pkg::*;
#(
  parameter int addr_width = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [addr_width-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic sleep,
  input wire logic lp_osc_in,
  input wire logic lp_osc_out,
  input wire logic overflow_flag,
  input wire logic wake_req,
  input wire logic timebase_valid,
  input wire logic compare_trigger
);
  logic taken;
  logic wr_pend;
  logic [7:0] wr_off;
  logic [1:0] since_ctrl;
  assign taken = hsel && hready && htrans[1];
  // remembers the data phase so register effects can be tied to their write
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_pend <= 1'b0;
      wr_off <= 8'h00;
    end else begin
      wr_pend <= taken && hwrite;
      wr_off <= haddr[7:0];
    end
  end
  // the mode output may lag the control write by a register stage
  always_ff @(posedge core_clk) begin
    if (srst || (wr_pend && wr_off == ctrl_offset)) begin
      since_ctrl <= 2'h0;
    end else if (since_ctrl != 2'h3) begin
      since_ctrl <= since_ctrl + 2'h1;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase without exactly one wait");
  a_wake_sleep: assert property (wake_req |-> overflow_flag && $past(sleep))
    else $error("wake without overflow in sleep");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake longer than one cycle");
  a_flag_clear: assert property ($fell(overflow_flag) |-> $past(wr_pend && wr_off == flag_offset))
    else $error("overflow flag dropped without a clearing write");
  a_timebase_cause: assert property ($changed(timebase_valid) |-> since_ctrl < 2'h3)
    else $error("time base status moved without a control write");
  a_osc_invert: assert property (lp_osc_out |-> !$past(lp_osc_in))
    else $error("oscillator output not the inverted input");
  a_trigger_pulse: assert property (compare_trigger |=> !compare_trigger)
    else $error("trigger longer than one cycle");
  a_trigger_noflag: assert property (compare_trigger && !overflow_flag |=> !overflow_flag [*2])
    else $error("trigger reset raised the overflow flag");
  a_trigger_sync: assert property (compare_trigger |-> timebase_valid)
    else $error("trigger while in asynchronous mode");
endmodule  // ext_clock_timer_props

// ===== testbench/count_source.sv
// external count pin model: a burst of pulses, then the pin stands low
module count_source (
  input wire logic core_clk,
  input wire logic start,
  input wire logic [7:0] pulses,
  input wire logic [7:0] half,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int left = 0;
  int tick = 0;
  initial pin = 1'b0;
  assign busy = left != 0;
  // each level lasts half cycles, never under two phases
  always @(posedge core_clk) begin
    if (start && left == 0) begin
      left <= 2 * pulses;
      tick <= half;
    end else if (left != 0) begin
      if (tick <= 1) begin
        pin <= ~pin;
        left <= left - 1;
        tick <= half;
      end else begin
        tick <= tick - 1;
      end
    end
  end
endmodule  // count_source

// ===== testbench/sixteen_bit_timer_counter_ext_clock_bench.sv
// self-checking bench for the sixteen-bit timer/counter
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module sixteen_bit_timer_counter_ext_clock_bench
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, sleep = 1'b0, start = 1'b0;
  logic hreadyout, hresp, pin, busy, lp_osc_out, overflow_flag, wake_req, timebase_valid, compare_trigger;
  logic [7:0] haddr = 8'h00, pulses = 8'h00, half = 8'h04;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q, v;
  logic [15:0] c;
  int failures = 0, compares = 0, wakes = 0, trigs = 0, n, seed = 32'h4662;
  logic [7:0] offs [8] = '{ctrl_offset, count_low_offset, count_high_offset, flag_offset,
    compare_low_offset, compare_high_offset, compare_mode_offset, 8'h1c};
  logic [31:0] msk [3] = '{32'hff, 32'hff, 32'hf};
  ext_clock_timer #(.addr_width(8)) i_ext_clock_timer (.core_clk(core_clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize_word), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sleep(sleep), .ext_count_input(pin),
    .lp_osc_in(pin), .lp_osc_out(lp_osc_out), .overflow_flag(overflow_flag), .wake_req(wake_req),
    .timebase_valid(timebase_valid), .compare_trigger(compare_trigger));
  count_source i_count_source (.core_clk(core_clk), .start(start), .pulses(pulses), .half(half), .pin(pin),
    .busy(busy));
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (wake_req === 1'b1) wakes++;
    if (compare_trigger === 1'b1) trigs++;
  end
  ////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= htrans_nonseq;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic preset(input logic [15:0] x);
    bus(1'b1, ctrl_offset, 32'h0);  // counter stopped before its bytes are written
    repeat (4) @(posedge core_clk);  // let a trigger already in flight clear the count first
    bus(1'b1, count_low_offset, {24'h0, x[7:0]});
    bus(1'b1, count_high_offset, {24'h0, x[15:8]});
  endtask
  task automatic read_count(output logic [15:0] x);
    logic [31:0] h;
    do begin
      bus(1'b0, count_high_offset, 32'h0);
      h = q;
      bus(1'b0, count_low_offset, 32'h0);
      x = {h[7:0], q[7:0]};
      bus(1'b0, count_high_offset, 32'h0);
    end while (q !== h);  // a carry between byte reads forces another pair
  endtask
  task automatic burst(input logic [7:0] p);
    pulses <= p;
    half <= 8'(4 + ($random(seed) & 3));
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    do @(posedge core_clk); while (busy === 1'b1);
    repeat (12) @(posedge core_clk);
  endtask
  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    foreach (offs[i]) begin
      bus(1'b0, offs[i], 32'h0);
      `CHK(q, 32'h0)
      `CHK(hresp, 1'b0)
    end
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      bus(1'b1, offs[4 + i], v);
      bus(1'b0, offs[4 + i], 32'h0);
      `CHK(q, v & msk[i])
    end
    bus(1'b1, compare_mode_offset, 32'h0);
    bus(1'b1, 8'h1c, 32'hffffffff);
    bus(1'b0, 8'h1c, 32'h0);
    `CHK(q, 32'h0)
    preset(16'h0);
    bus(1'b1, ctrl_offset, 32'h1);
    repeat (400) @(posedge core_clk);
    bus(1'b1, ctrl_offset, 32'h0);
    read_count(c);
    `CHK(c >= 99 && c <= 102, 1'b1)
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 2; s++) begin
        for (int k = 0; k < 4; k++) begin
          n = (m == 0 && s == 1) ? 0 : 16 >> k;
          preset(16'hfff8);
          bus(1'b1, ctrl_offset, {26'h0, k[1:0], m[0], m[0], 2'h3});
          repeat (20) @(posedge core_clk);  // oscillator start-up allowance
          sleep <= s[0];
          burst(8'd16);
          sleep <= 1'b0;
          `CHK(timebase_valid, ~m[0])
          `CHK(lp_osc_out, m[0])
          read_count(c);
          `CHK(c, 16'(32'hfff8 + n))
          `CHK(overflow_flag, n >= 8)
          `CHK(wakes, (n >= 8 && s == 1) ? 1 : 0)
          wakes = 0;
          bus(1'b1, flag_offset, 32'h1);
          bus(1'b0, flag_offset, 32'h0);
          `CHK(q, 32'h0)
        end
      end
    end
    v = 8 + ($random(seed) & 7);
    preset(16'h0);
    bus(1'b1, compare_low_offset, v);
    bus(1'b1, compare_high_offset, 32'h0);
    bus(1'b1, compare_mode_offset, {28'h0, special_event_mode});
    trigs = 0;
    bus(1'b1, ctrl_offset, 32'h1);
    repeat (600) @(posedge core_clk);
    read_count(c);
    `CHK(c <= v[15:0] + 16'h1, 1'b1)
    `CHK(trigs > 4, 1'b1)
    `CHK(overflow_flag, 1'b0)
    preset(v[15:0] - 16'h2);
    bus(1'b1, ctrl_offset, 32'h7);
    trigs = 0;
    burst(8'd4);
    read_count(c);
    `CHK(c, v[15:0] + 16'h2)
    `CHK(trigs, 0)
    wrap_up();
  end
  // the sequence needs about five thousand cycles; ten times that cuts a hang
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
endmodule  // sixteen_bit_timer_counter_ext_clock_bench
bind ext_clock_timer ext_clock_timer_props #(.addr_width(addr_width)) i_props (.core_clk(core_clk), .srst(srst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .sleep(sleep), .lp_osc_in(lp_osc_in), .lp_osc_out(lp_osc_out), .overflow_flag(overflow_flag),
  .wake_req(wake_req), .timebase_valid(timebase_valid), .compare_trigger(compare_trigger));
